/* File: test/test_pieb_bank.sv */
/*
 * Self-checking bench for the peripheral interrupt-enable bank top.
 * Assumes the bank answers reads one cycle after the strobe and that
 * request flags are plain levels on mclk.
 */
`timescale 1ns/1ps
module test_pieb_bank;
    logic                          mclk;
    logic                          reset_n;
    logic [11:0]                   bus_addr;
    logic [7:0]                    bus_wdata;
    logic                          bus_wr;
    logic                          bus_rd;
    logic [7:0]                    bus_rdata;
    logic [pieb_pkg::EN_W-1:0]     req_flag;
    logic [pieb_pkg::EN_W-1:0]     irq_req;
    logic                          irq;
    logic [pieb_pkg::EN_W-1:0]     en_exp;
    logic [7:0]                    impl [6];
    logic [7:0]                    d;
    logic [31:0]                   seed;
    int                            err_count;
    int                            check_count;
    int                            cycles;
    int                            k;

    pieb_bank DUT (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_wr    (bus_wr),
        .bus_rd    (bus_rd),
        .bus_rdata (bus_rdata),
        .req_flag  (req_flag),
        .irq_req   (irq_req),
        .irq       (irq)
    );

    always #25 mclk = ~mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    function automatic logic [11:0] ofs(input int r);
        return pieb_pkg::OFS_EN5 + 12'(r);
    endfunction

    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge mclk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd   <= 1'b0;
        #1 v = bus_rdata;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        mclk        = 1'b0;
        reset_n     = 1'b0;
        bus_addr    = '0;
        bus_wdata   = '0;
        bus_wr      = 1'b0;
        bus_rd      = 1'b0;
        req_flag    = '0;
        en_exp      = '0;
        err_count   = 0;
        check_count = 0;
        cycles      = 0;
        seed        = 32'heb0e;
        impl = '{8'hF7, 8'hFF, 8'hEF, 8'hFF, 8'h2F, 8'hFF};
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;

        for (k = 0; k < 6; k++) begin
            rd(ofs(k), d);
            chk("enable after reset", d, 8'h00);
        end
        rd(pieb_pkg::OFS_STAT, d);
        chk("status after reset", d, 8'h00);
        rd(pieb_pkg::OFS_MASK, d);
        chk("mask after reset", d, 8'h00);
        $display("test reset done");

        // All ones exposes every absent bit; rdata must drop after one cycle
        for (k = 0; k < 6; k++) begin
            wr(ofs(k), 8'hFF);
            rd(ofs(k), d);
            chk("implemented bits", d, impl[k]);
            @(posedge mclk);
            #1 chk("rdata after read", bus_rdata, 8'h00);
            wr(ofs(k), 8'h00);
            rd(ofs(k), d);
            chk("enable cleared", d, 8'h00);
        end
        $display("test bit map done");

        wr(12'h4A2, 8'hFF);
        wr(12'h4A9, 8'hFF);
        rd(12'h4A2, d);
        chk("unmapped below", d, 8'h00);
        rd(12'h4A9, d);
        chk("unmapped above", d, 8'h00);
        $display("test unmapped done");

        repeat (24) begin
            seed = lfsr(seed);
            k = int'(seed[18:16]) % 6;
            wr(ofs(k), seed[7:0]);
            en_exp[k*8 +: 8] = seed[7:0] & impl[k];
            rd(ofs(k), d);
            chk("random readback", d, seed[7:0] & impl[k]);
        end
        repeat (8) begin
            seed = lfsr(seed);
            @(posedge mclk);
            req_flag <= {seed[15:0], lfsr(seed)};
            @(posedge mclk);
            #1 chk("gated request", irq_req, req_flag & en_exp);
        end
        $display("test random done");

        for (k = 0; k < 6; k++) begin
            wr(ofs(k), 8'h00);
        end
        wr(pieb_pkg::OFS_EN8, 8'h04);
        wr(pieb_pkg::OFS_EN7, 8'h08);
        @(posedge mclk);
        req_flag <= '1;
        repeat (2) @(posedge mclk);
        #1 chk("lone error enables", irq_req,
               (48'h1 << pieb_pkg::UART_PORT2_FRAMING_ERR_EN) |
               (48'h1 << pieb_pkg::I2C_PORT1_ERROR_EN));
        $display("test error enables done");

        @(posedge mclk);
        req_flag <= '0;
        wr(pieb_pkg::OFS_MASK, 8'h3F);
        for (k = 0; k < 6; k++) begin
            wr(ofs(k), 8'hFF);
        end
        rd(pieb_pkg::OFS_STAT, d);
        chk("irq idle", irq, 1'b0);
        @(posedge mclk);
        // Seventh register bit 4 is absent, so drive an implemented source of group 2
        req_flag[pieb_pkg::LOGIC_CELL3_EN] <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("irq raised", irq, 1'b1);
        rd(pieb_pkg::OFS_STAT, d);
        chk("status group 2", d, 8'h04);
        chk("irq after status read", irq, 1'b0);
        wr(pieb_pkg::OFS_MASK, 8'h00);
        @(posedge mclk);
        req_flag[32] <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("irq masked", irq, 1'b0);
        rd(pieb_pkg::OFS_STAT, d);
        chk("status group 4", d, 8'h10);
        rd(pieb_pkg::OFS_MASK, d);
        chk("mask readback", d, 8'h00);
        $display("test interrupt done");
        results();
    end
endmodule

/* File: verilog/pieb_bank.sv */
/*
 * Peripheral interrupt-enable bank: six enable registers, request gating,
 * a sticky group event status with mask, and one interrupt output.
 * Assumes a single-cycle strobe master on mclk and flags on mclk.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module pieb_bank #(
    parameter int ADDR_W = pieb_pkg::ADDR_W
) (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic [ADDR_W-1:0]        bus_addr,
    input  wire logic [7:0]               bus_wdata,
    input  wire logic                     bus_wr,
    input  wire logic                     bus_rd,
    output logic      [7:0]               bus_rdata,
    input  wire logic [pieb_pkg::EN_W-1:0] req_flag,
    output logic      [pieb_pkg::EN_W-1:0] irq_req,
    output logic                          irq
);
    if (ADDR_W < 12) begin : g_bad_addr
        $error("pieb_bank needs at least 12 address bits");
    end

    pieb_core_if cif ();

    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [7:0] rd_value;
    logic [7:0] rdata_q;
    logic [5:0] stat_q;
    logic [5:0] stat_d;
    logic [5:0] mask_q;
    logic       stat_clr;

    // Decode shared by the write and read paths
    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [3:0] r;
        r = pieb_pkg::IDX_NONE;
        if (a == ADDR_W'(pieb_pkg::OFS_EN5)) begin
            r = 4'h0;
        end else if (a == ADDR_W'(pieb_pkg::OFS_EN6)) begin
            r = 4'h1;
        end else if (a == ADDR_W'(pieb_pkg::OFS_EN7)) begin
            r = 4'h2;
        end else if (a == ADDR_W'(pieb_pkg::OFS_EN8)) begin
            r = 4'h3;
        end else if (a == ADDR_W'(pieb_pkg::OFS_EN9)) begin
            r = 4'h4;
        end else if (a == ADDR_W'(pieb_pkg::OFS_EN10)) begin
            r = 4'h5;
        end else if (a == ADDR_W'(pieb_pkg::OFS_STAT)) begin
            r = pieb_pkg::IDX_STAT;
        end else if (a == ADDR_W'(pieb_pkg::OFS_MASK)) begin
            r = pieb_pkg::IDX_MASK;
        end
        return r;
    endfunction

    assign wr_idx = reg_index(bus_addr);
    assign rd_idx = reg_index(bus_addr);

    // Write selects for the enable store
    always_comb begin
        cif.wr_sel = '0;
        if (bus_wr && wr_idx < 4'h6) begin
            cif.wr_sel[wr_idx[2:0]] = 1'b1;
        end
    end

    assign cif.wdata    = bus_wdata;
    assign cif.req_flag = req_flag;

    pieb_enable_file u_enables (
        .mclk    (mclk),
        .reset_n (reset_n),
        .cif     (cif)
    );

    pieb_req_gate u_gate (
        .mclk    (mclk),
        .reset_n (reset_n),
        .cif     (cif)
    );

    assign irq_req = cif.req_out;

    // Read mux; masks already keep absent bits at zero
    always_comb begin
        rd_value = 8'h00;
        if (rd_idx < 4'h6) begin
            rd_value = cif.en[rd_idx[2:0]*8 +: 8];
        end else if (rd_idx == pieb_pkg::IDX_STAT) begin
            rd_value = {2'b00, stat_q};
        end else if (rd_idx == pieb_pkg::IDX_MASK) begin
            rd_value = {2'b00, mask_q};
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (bus_rd) begin
            rdata_q <= rd_value;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign bus_rdata = rdata_q;

    // A group event in the clearing cycle survives the read
    assign stat_clr = bus_rd && (rd_idx == pieb_pkg::IDX_STAT);
    assign stat_d   = (stat_q & ~{6{stat_clr}}) | cif.grp_rise;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= pieb_pkg::RST_STAT;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= pieb_pkg::RST_MASK;
        end else if (bus_wr && wr_idx == pieb_pkg::IDX_MASK) begin
            mask_q <= bus_wdata[5:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    sequence s_wr_hit(logic [3:0] idx);
        bus_wr && (wr_idx == idx);
    endsequence

    sequence s_rd_hit(logic [3:0] idx);
        bus_rd && (rd_idx == idx);
    endsequence

    property p_wr_back(logic [3:0] idx, logic [7:0] m);
        @(posedge mclk) disable iff (!reset_n)
        s_wr_hit(idx) |=> (cif.en[idx*8 +: 8] == ($past(bus_wdata) & m));
    endproperty

    a_fifth_write: assert property (p_wr_back(4'h0, 8'hF7))
        else $error("fifth enable register write mismatch");
    a_sixth_write: assert property (p_wr_back(4'h1, 8'hFF))
        else $error("sixth enable register write mismatch");
    a_seventh_write: assert property (p_wr_back(4'h2, 8'hEF))
        else $error("seventh enable register write mismatch");
    a_eighth_write: assert property (p_wr_back(4'h3, 8'hFF))
        else $error("eighth enable register write mismatch");
    a_ninth_write: assert property (p_wr_back(4'h4, 8'h2F))
        else $error("ninth enable register write mismatch");
    a_tenth_write: assert property (p_wr_back(4'h5, 8'hFF))
        else $error("tenth enable register write mismatch");

    a_enable_hold: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !(bus_wr && wr_idx < 4'h6) |=> $stable(cif.en))
        else $error("enable changed without a write");

    a_enable_readback: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_rd_hit(4'h3) ##0 !bus_wr |=> bus_rdata == $past(cif.en[31:24]))
        else $error("eighth register read-back mismatch");

    a_framing_solo: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_wr_hit(4'h3) |=>
            cif.en[pieb_pkg::UART_PORT2_FRAMING_ERR_EN] == $past(bus_wdata[2]) &&
            cif.en[pieb_pkg::UART_PORT2_GENERAL_EN] == $past(bus_wdata[3]))
        else $error("uart2 framing enable not independent");

    a_i2c_err_solo: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_wr_hit(4'h2) |=>
            cif.en[pieb_pkg::I2C_PORT1_ERROR_EN] == $past(bus_wdata[3]) &&
            cif.en[pieb_pkg::I2C_PORT1_GENERAL_EN] == $past(bus_wdata[2]))
        else $error("i2c1 error enable not independent");

    a_req_gating: assert property (
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> irq_req == $past(req_flag & cif.en))
        else $error("forwarded request does not match flag and enable");

    a_reserved_zero: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (cif.en & ~pieb_pkg::impl_flat()) == '0)
        else $error("absent enable bit holds a one");

    a_reserved_read: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_rd_hit(4'h4) |=> bus_rdata[7:6] == 2'b00 && bus_rdata[4] == 1'b0)
        else $error("absent bit of ninth register read as one");

    a_status_clear: assert property (
        @(posedge mclk) disable iff (!reset_n)
        s_rd_hit(pieb_pkg::IDX_STAT) ##0 cif.grp_rise == '0 |=> stat_q == 6'h00)
        else $error("status not cleared by its read");

    a_status_sticky: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (stat_q != 6'h00) && !stat_clr |=> (stat_q & $past(stat_q)) == $past(stat_q))
        else $error("status bit lost without a read");

    a_rdata_quiet: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data outside the answer cycle");

    a_irq_follow: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (cif.grp_rise & mask_q) != '0 |=> irq)
        else $error("unmasked event did not raise the interrupt");
endmodule

/* File: verilog/pieb_core_if.sv */
/*
 * Carrier between the bank top, its enable store and its request gate.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/1ps
interface pieb_core_if;
    logic [7:0]              wdata;
    logic [pieb_pkg::NUM_REGS-1:0] wr_sel;
    logic [pieb_pkg::EN_W-1:0] en;
    logic [pieb_pkg::EN_W-1:0] req_flag;
    logic [pieb_pkg::EN_W-1:0] req_out;
    logic [pieb_pkg::NUM_REGS-1:0] grp_rise;

    modport top  (output wdata, wr_sel, req_flag, input en, req_out, grp_rise);
    modport regs (input wdata, wr_sel, output en);
    modport gate (input en, req_flag, output req_out, grp_rise);
endinterface

/* File: verilog/pieb_enable_file.sv */
/*
 * Six byte-wide enable registers with fixed implemented-bit masks.
 * Assumes one-hot write selects from the bank decoder.
 */
`timescale 1ns/1ps
module pieb_enable_file (
    input wire logic mclk,
    input wire logic reset_n,
    pieb_core_if.regs cif
);
    for (genvar k = 0; k < pieb_pkg::NUM_REGS; k++) begin : g_reg
        logic [7:0] en_q;
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                en_q <= pieb_pkg::RST_EN;
            end else if (cif.wr_sel[k]) begin
                // Unimplemented positions never take a 1
                en_q <= cif.wdata & pieb_pkg::IMPL_MASK[k];
            end
        end
        assign cif.en[k*8 +: 8] = en_q;
    end
endmodule

/* File: verilog/pieb_pkg.sv */
/*
 * Constants of the peripheral interrupt-enable bank: offsets, masks,
 * reset values and flat bit positions of every enable.
 * Assumes byte-wide registers on a 12-bit internal address bus.
 */
package pieb_pkg;
    localparam int          NUM_REGS = 6;
    localparam int          REG_W    = 8;
    localparam int          EN_W     = NUM_REGS * REG_W;
    localparam int          ADDR_W   = 12;

    localparam logic [11:0] OFS_EN5  = 12'h4A3;
    localparam logic [11:0] OFS_EN6  = 12'h4A4;
    localparam logic [11:0] OFS_EN7  = 12'h4A5;
    localparam logic [11:0] OFS_EN8  = 12'h4A6;
    localparam logic [11:0] OFS_EN9  = 12'h4A7;
    localparam logic [11:0] OFS_EN10 = 12'h4A8;
    localparam logic [11:0] OFS_STAT = 12'h4B0;
    localparam logic [11:0] OFS_MASK = 12'h4B1;

    localparam logic [3:0]  IDX_STAT = 4'h6;
    localparam logic [3:0]  IDX_MASK = 4'h7;
    localparam logic [3:0]  IDX_NONE = 4'hF;

    localparam logic [7:0]  RST_EN   = 8'h00;
    localparam logic [5:0]  RST_STAT = 6'h00;
    localparam logic [5:0]  RST_MASK = 6'h00;

    // Implemented bits per register, index 0 is the fifth register
    localparam logic [7:0]  IMPL_MASK [NUM_REGS] = '{8'hF7, 8'hFF, 8'hEF, 8'hFF, 8'h2F, 8'hFF};

    // Flat positions in the enable vector: register k, bit b -> k*8+b
    localparam int MODULATOR2_PARAM_EN = 7, MODULATOR2_PERIOD_EN = 6;
    localparam int TIMER3_GATE_EN = 5, TIMER3_OVERFLOW_EN = 4;
    localparam int SPI_PORT2_GENERAL_EN = 2, SPI_PORT2_TRANSMIT_EN = 1, SPI_PORT2_RECEIVE_EN = 0;
    localparam int DMA_CH2_ABORT_EN = 15, DMA_CH2_OVERRUN_EN = 14;
    localparam int DMA_CH2_DEST_COUNT_EN = 13, DMA_CH2_SRC_COUNT_EN = 12;
    localparam int OSCILLATOR1_EN = 11, WAVEFORM_GEN1_EN = 10, LOGIC_CELL2_EN = 9, EXT_PIN1_EN = 8;
    localparam int MODULATOR3_PARAM_EN = 23, MODULATOR3_PERIOD_EN = 22, LOGIC_CELL3_EN = 21;
    localparam int I2C_PORT1_ERROR_EN = 19, I2C_PORT1_GENERAL_EN = 18;
    localparam int I2C_PORT1_TRANSMIT_EN = 17, I2C_PORT1_RECEIVE_EN = 16;
    localparam int MEMORY_SCANNER_EN = 31, CAPTURE_COMPARE2_EN = 30;
    localparam int TIMER5_GATE_EN = 29, TIMER5_OVERFLOW_EN = 28;
    localparam int UART_PORT2_GENERAL_EN = 27, UART_PORT2_FRAMING_ERR_EN = 26;
    localparam int UART_PORT2_TRANSMIT_EN = 25, UART_PORT2_RECEIVE_EN = 24;
    localparam int LOGIC_CELL4_EN = 37, UART_PORT3_GENERAL_EN = 35;
    localparam int UART_PORT3_FRAMING_ERR_EN = 34;
    localparam int UART_PORT3_TRANSMIT_EN = 33, UART_PORT3_RECEIVE_EN = 32;
    localparam int DMA_CH3_ABORT_EN = 47, DMA_CH3_OVERRUN_EN = 46;
    localparam int DMA_CH3_DEST_COUNT_EN = 45, DMA_CH3_SRC_COUNT_EN = 44;
    localparam int OSCILLATOR2_EN = 43, WAVEFORM_GEN2_EN = 42, LOGIC_CELL5_EN = 41, EXT_PIN2_EN = 40;

    function automatic logic [EN_W-1:0] impl_flat();
        logic [EN_W-1:0] m;
        m = '0;
        for (int k = 0; k < NUM_REGS; k++) begin
            m[k*REG_W +: REG_W] = IMPL_MASK[k];
        end
        return m;
    endfunction
endpackage

/* File: verilog/pieb_req_gate.sv */
/*
 * Forwards each request flag when its enable is set, and reports per
 * register group the rise from no forwarded request to at least one.
 * Assumes request flags come from logic on the same clock.
 */
`timescale 1ns/1ps
module pieb_req_gate (
    input wire logic mclk,
    input wire logic reset_n,
    pieb_core_if.gate cif
);
    localparam int G = pieb_pkg::NUM_REGS;

    logic [pieb_pkg::EN_W-1:0] req_q;
    logic [G-1:0]              grp_now;
    logic [G-1:0]              grp_prev_q;

    // Flags are only looked at, never cleared, so disabling keeps them
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
        end else begin
            req_q <= cif.req_flag & cif.en;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            grp_prev_q <= '0;
        end else begin
            grp_prev_q <= grp_now;
        end
    end

    for (genvar k = 0; k < G; k++) begin : g_grp
        assign grp_now[k] = |req_q[k*8 +: 8];
    end

    assign cif.req_out  = req_q;
    assign cif.grp_rise = grp_now & ~grp_prev_q;
endmodule
